// File: core/dstc_channel_ctrl.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// How it works
// - Every channel has its own independent control register.
// - Control fields reset to zero, fully read/write.
// - Bit 7 picks byte or word transfer.
// - Bit 6 steps memory pointer up or down.
// - Step is one for bytes, two for words.
// - Idle mode holds the memory pointer still.
// - Repeat bit and irq enable select mode.
// - End interrupt only with irq enable set.
// - Bit 4 swaps memory and I/O roles.
// - Code 0001 starts on converter end.
// - Codes 0100-0111 select serial channel events.
// - Codes 1000-1010 select timer channel A events.
// - I/O address upper byte forced, never steps.
// - Full counter decrements; zero clears enable.
// - Repeat reloads low byte and restores pointer.
// - Shared source serves highest priority channel first.
module dstc_channel_ctrl
  import dstc_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic [5:0] reg_addr, // Register word address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_we, // Write strobe, one cycle.
  input wire logic reg_re, // Read strobe, one cycle.
  output logic [15:0] reg_rdata, // Read data, cycle after the strobe.
  input wire logic [EVT_COUNT-1:0] periph_evt, // Peripheral event pulses.
  output logic xfer_valid, // A transfer is being requested.
  input wire logic xfer_done, // The bus finished the transfer.
  output logic [23:0] xfer_src_addr, // Source address of the transfer.
  output logic [23:0] xfer_dst_addr, // Destination address.
  output logic xfer_word, // High for a 16-bit word transfer.
  output logic [1:0] xfer_chan, // Channel that owns the transfer.
  output logic irq // Level interrupt, unmasked end status.
);

  localparam int CW = 2;

  logic [7:0] ctrl_q [NCH]; // Control register per channel.
  logic [23:0] mem_q [NCH]; // Stepping memory pointer.
  logic [23:0] start_q [NCH]; // Pointer value at start of count.
  logic [15:0] io_q [NCH]; // Fixed I/O pointer, low 16 bits.
  logic [15:0] cnt_q [NCH]; // Transfer counter.
  logic [NCH-1:0] en_q; // Channel enable bits.
  logic [NCH-1:0] ie_q; // End interrupt enable bits.
  logic [NCH-1:0] pend_q; // Activation seen, not yet served.
  logic [NCH-1:0] stat_q; // Sticky end status.
  logic [NCH-1:0] mask_q; // Interrupt mask, one lets status through.
  logic [NCH-1:0] hit; // Activation of each channel this cycle.
  logic [NCH-1:0] end_set; // End event of each channel this cycle.
  dstc_state_e state_q; // Engine state.
  logic [CW-1:0] sel_q; // Channel being served.
  logic [CW-1:0] pick; // Highest priority pending channel.
  logic any_pend; // At least one channel is pending.
  logic grant; // A new transfer starts this cycle.
  logic finish; // The current transfer completes this cycle.
  logic [23:0] mem_next; // Updated pointer of the served channel.
  logic [15:0] cnt_next; // Updated counter of the served channel.
  logic en_next; // Updated enable of the served channel.
  logic end_evt; // Served channel ends with an interrupt.

  // True when the address selects a given slot of a given channel.
  function automatic logic chan_reg(input logic [5:0] a, input int ch,
                                    input logic [2:0] ofs);
    chan_reg = (a < ADDR_CHAN_TOP) && (a[5:3] == 3'(ch)) && (a[2:0] == ofs);
  endfunction

  // Returns the selected peripheral event for an activation code.
  function automatic logic src_hit(input logic [3:0] code,
                                   input logic [EVT_COUNT-1:0] evt);
    if (code == SRC_ADC_END) begin
      src_hit = evt[EVT_ADC_END];
    end else if (code == SRC_SER0_TX) begin
      src_hit = evt[EVT_SER0_TX];
    end else if (code == SRC_SER0_RX) begin
      src_hit = evt[EVT_SER0_RX];
    end else if (code == SRC_SER1_TX) begin
      src_hit = evt[EVT_SER1_TX];
    end else if (code == SRC_SER1_RX) begin
      src_hit = evt[EVT_SER1_RX];
    end else if (code == SRC_TMR0_A) begin
      src_hit = evt[EVT_TMR0_A];
    end else if (code == SRC_TMR1_A) begin
      src_hit = evt[EVT_TMR1_A];
    end else if (code == SRC_TMR2_A) begin
      src_hit = evt[EVT_TMR2_A];
    end else begin
      src_hit = 1'b0;
    end
  endfunction

  // Each enabled channel watches the event picked by its own code.
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_hit
      assign hit[g] = en_q[g] && src_hit(ctrl_q[g][3:0], periph_evt);
      assign end_set[g] = finish && end_evt && (sel_q == CW'(g));
    end
  endgenerate

  // Lowest channel number has the highest relative priority.
  // A flag left pending by a channel whose count just ended is ignored.
  always_comb begin
    pick = '0;
    any_pend = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_q[i] && en_q[i]) begin
        pick = CW'(i);
        any_pend = 1'b1;
      end
    end
  end

  assign grant = (state_q == DSTC_IDLE) && any_pend;
  assign finish = (state_q == DSTC_BUSY) && xfer_done;
  assign xfer_valid = (state_q == DSTC_BUSY);

  // Next pointer, counter and enable of the channel being served.
  always_comb begin
    logic [7:0] c;
    logic [23:0] step;
    logic idle_m;
    logic rpt_m;
    logic [7:0] low;
    c = ctrl_q[sel_q];
    step = c[CTRL_SIZE_BIT] ? STEP_WORD : STEP_BYTE;
    idle_m = c[CTRL_RPT_BIT] && ie_q[sel_q];
    rpt_m = c[CTRL_RPT_BIT] && !ie_q[sel_q];
    low = cnt_q[sel_q][7:0] - 8'h01;
    en_next = en_q[sel_q];
    end_evt = 1'b0;
    if (idle_m) begin
      mem_next = mem_q[sel_q];
    end else if (c[CTRL_DOWN_BIT]) begin
      mem_next = mem_q[sel_q] - step;
    end else begin
      mem_next = mem_q[sel_q] + step;
    end
    if (rpt_m) begin
      // Only the low byte counts; the high byte holds the reload.
      if (low == 8'h00) begin
        cnt_next = {cnt_q[sel_q][15:8], cnt_q[sel_q][15:8]};
        mem_next = start_q[sel_q];
      end else begin
        cnt_next = {cnt_q[sel_q][15:8], low};
      end
    end else begin
      cnt_next = cnt_q[sel_q] - 16'h0001;
      if (cnt_next == 16'h0000) begin
        en_next = 1'b0;
        end_evt = ie_q[sel_q];
      end
    end
  end

  // Control registers, one per channel, written only by software.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_q[i] <= CTRL_RESET;
      end
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (reg_we && chan_reg(reg_addr, i, OFS_CTRL)) begin
          ctrl_q[i] <= reg_wdata[7:0];
        end
      end
    end
  end

  // Pointers and counters; a software write wins over an update.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        mem_q[i] <= 24'h000000;
        start_q[i] <= 24'h000000;
        io_q[i] <= DATA_ZERO;
        cnt_q[i] <= DATA_ZERO;
      end
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (reg_we && chan_reg(reg_addr, i, OFS_MEM_LO)) begin
          mem_q[i][15:0] <= reg_wdata;
        end else if (reg_we && chan_reg(reg_addr, i, OFS_MEM_HI)) begin
          mem_q[i][23:16] <= reg_wdata[7:0];
        end else if (finish && sel_q == CW'(i)) begin
          mem_q[i] <= mem_next;
        end
        if (reg_we && chan_reg(reg_addr, i, OFS_IO)) begin
          io_q[i] <= reg_wdata;
        end
        if (reg_we && chan_reg(reg_addr, i, OFS_CNT)) begin
          cnt_q[i] <= reg_wdata;
        end else if (finish && sel_q == CW'(i)) begin
          cnt_q[i] <= cnt_next;
        end
        // The restore point is caught when software starts the channel.
        if (reg_we && chan_reg(reg_addr, i, OFS_EN) &&
            reg_wdata[EN_ENABLE_BIT] && !en_q[i]) begin
          start_q[i] <= mem_q[i];
        end
      end
    end
  end

  // Enable and interrupt enable bits of each channel.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q <= '0;
      ie_q <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (reg_we && chan_reg(reg_addr, i, OFS_EN)) begin
          en_q[i] <= reg_wdata[EN_ENABLE_BIT];
          ie_q[i] <= reg_wdata[EN_IRQ_BIT];
        end else if (finish && sel_q == CW'(i)) begin
          en_q[i] <= en_next;
        end
      end
    end
  end

  // Pending activations; a new hit wins over the grant that clears it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (hit[i]) begin
          pend_q[i] <= 1'b1;
        end else if (!en_q[i]) begin
          pend_q[i] <= 1'b0;
        end else if (grant && pick == CW'(i)) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Engine: serves one channel at a time and waits for the bus.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= DSTC_IDLE;
      sel_q <= '0;
    end else if (ce) begin
      case (state_q)
        DSTC_IDLE: begin
          if (grant) begin
            state_q <= DSTC_BUSY;
            sel_q <= pick;
          end
        end
        DSTC_BUSY: begin
          if (xfer_done) begin
            state_q <= DSTC_IDLE;
          end
        end
        default: begin
          state_q <= DSTC_IDLE;
        end
      endcase
    end
  end

  // Transfer outputs are latched when a channel is granted.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_src_addr <= 24'h000000;
      xfer_dst_addr <= 24'h000000;
      xfer_word <= 1'b0;
      xfer_chan <= 2'h0;
    end else if (ce && grant) begin
      xfer_word <= ctrl_q[pick][CTRL_SIZE_BIT];
      xfer_chan <= pick;
      if (ctrl_q[pick][CTRL_DIR_BIT]) begin
        xfer_src_addr <= {IO_UPPER, io_q[pick]};
        xfer_dst_addr <= mem_q[pick];
      end else begin
        xfer_src_addr <= mem_q[pick];
        xfer_dst_addr <= {IO_UPPER, io_q[pick]};
      end
    end
  end

  // Sticky end status, cleared by writing one; a set wins over the clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= '0;
      mask_q <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (end_set[i]) begin
          stat_q[i] <= 1'b1;
        end else if (reg_we && reg_addr == ADDR_IRQ_STAT &&
                     reg_wdata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      if (reg_we && reg_addr == ADDR_IRQ_MASK) begin
        mask_q <= reg_wdata[NCH-1:0];
      end
      irq <= |(stat_q & mask_q);
    end
  end

  // Read data appear in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= DATA_ZERO;
    end else if (ce) begin
      reg_rdata <= DATA_ZERO;
      if (reg_re) begin
        if (reg_addr == ADDR_IRQ_STAT) begin
          reg_rdata <= 16'(stat_q);
        end else if (reg_addr == ADDR_IRQ_MASK) begin
          reg_rdata <= 16'(mask_q);
        end else begin
          for (int i = 0; i < NCH; i++) begin
            if (chan_reg(reg_addr, i, OFS_CTRL)) begin
              reg_rdata <= {8'h00, ctrl_q[i]};
            end else if (chan_reg(reg_addr, i, OFS_MEM_LO)) begin
              reg_rdata <= mem_q[i][15:0];
            end else if (chan_reg(reg_addr, i, OFS_MEM_HI)) begin
              reg_rdata <= {8'h00, mem_q[i][23:16]};
            end else if (chan_reg(reg_addr, i, OFS_IO)) begin
              reg_rdata <= io_q[i];
            end else if (chan_reg(reg_addr, i, OFS_CNT)) begin
              reg_rdata <= cnt_q[i];
            end else if (chan_reg(reg_addr, i, OFS_EN)) begin
              reg_rdata <= {14'h0000, ie_q[i], en_q[i]};
            end
          end
        end
      end
    end
  end

endmodule

// File: core/dstc_pkg.sv
package dstc_pkg;
  // Register slots inside one channel block; the channel number is addr[5:3].
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_MEM_LO = 3'h1;
  localparam logic [2:0] OFS_MEM_HI = 3'h2;
  localparam logic [2:0] OFS_IO = 3'h3;
  localparam logic [2:0] OFS_CNT = 3'h4;
  localparam logic [2:0] OFS_EN = 3'h5;
  // Shared interrupt registers above the channel blocks.
  localparam logic [5:0] ADDR_CHAN_TOP = 6'h20;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h20;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h21;
  // Field positions of channel_control_short.
  localparam int CTRL_SIZE_BIT = 7;
  localparam int CTRL_DOWN_BIT = 6;
  localparam int CTRL_RPT_BIT = 5;
  localparam int CTRL_DIR_BIT = 4;
  // Field positions of the per-channel enable register.
  localparam int EN_ENABLE_BIT = 0;
  localparam int EN_IRQ_BIT = 1;
  // Values after reset.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  // Address constants.
  localparam logic [7:0] IO_UPPER = 8'hFF;
  localparam logic [23:0] STEP_BYTE = 24'h000001;
  localparam logic [23:0] STEP_WORD = 24'h000002;
  // Activation source codes.
  localparam logic [3:0] SRC_ADC_END = 4'h1;
  localparam logic [3:0] SRC_SER0_TX = 4'h4;
  localparam logic [3:0] SRC_SER0_RX = 4'h5;
  localparam logic [3:0] SRC_SER1_TX = 4'h6;
  localparam logic [3:0] SRC_SER1_RX = 4'h7;
  localparam logic [3:0] SRC_TMR0_A = 4'h8;
  localparam logic [3:0] SRC_TMR1_A = 4'h9;
  localparam logic [3:0] SRC_TMR2_A = 4'hA;
  // Bit positions of the peripheral event vector.
  localparam int EVT_ADC_END = 0;
  localparam int EVT_SER0_TX = 1;
  localparam int EVT_SER0_RX = 2;
  localparam int EVT_SER1_TX = 3;
  localparam int EVT_SER1_RX = 4;
  localparam int EVT_TMR0_A = 5;
  localparam int EVT_TMR1_A = 6;
  localparam int EVT_TMR2_A = 7;
  localparam int EVT_COUNT = 8;
  // Engine states.
  typedef enum logic [1:0] {
    DSTC_IDLE = 2'b01,
    DSTC_BUSY = 2'b10
  } dstc_state_e;
endpackage

// File: sim/dstc_channel_ctrl_properties.sv
`timescale 1ns/1ps
// Watches the transfer and interrupt ports of the channel control block.
module dstc_channel_ctrl_chk #(
  parameter int NCH = 4 // Channels in use.
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic reg_we, // Write strobe.
  input wire logic reg_re, // Read strobe.
  input wire logic [15:0] reg_rdata, // Read data.
  input wire logic [7:0] periph_evt, // Peripheral events.
  input wire logic xfer_valid, // Transfer request.
  input wire logic xfer_done, // Transfer finished.
  input wire logic [23:0] xfer_src_addr, // Source address.
  input wire logic [23:0] xfer_dst_addr, // Destination address.
  input wire logic xfer_word, // Word transfer.
  input wire logic [1:0] xfer_chan, // Owning channel.
  input wire logic irq // Interrupt level.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Read data stays zero unless a read was taken one edge before.
  rdata_quiet_a: assert property (
    !$past(reg_re) |-> reg_rdata == 16'h0000) else $error("stray read data");
  // One side of every transfer is the fixed I/O window.
  io_upper_a: assert property (
    xfer_valid |-> xfer_src_addr[23:16] == 8'hFF ||
    xfer_dst_addr[23:16] == 8'hFF) else $error("no I/O side");
  // A waiting request holds every qualifier still.
  xfer_hold_a: assert property (
    xfer_valid && !xfer_done |=> xfer_valid && $stable(xfer_src_addr) &&
    $stable(xfer_dst_addr) && $stable(xfer_word) && $stable(xfer_chan))
    else $error("request moved");
  // Completion ends the request at the next edge.
  end_release_a: assert property (
    xfer_valid && xfer_done |=> !xfer_valid) else $error("request held");
  // A grant follows an event two cycles back or a busy engine.
  grant_cause_a: assert property (
    $rose(xfer_valid) |-> $past(|periph_evt, 2) || $past(xfer_valid, 2))
    else $error("grant without event");
  // The interrupt rises only after a completion or a register write.
  irq_rise_a: assert property (
    $rose(irq) |-> $past(xfer_done, 2) || $past(reg_we, 2))
    else $error("irq rose alone");
  // The interrupt falls only after a register write.
  irq_fall_a: assert property (
    $fell(irq) |-> $past(reg_we, 2)) else $error("irq fell alone");
  // Only existing channels own transfers.
  chan_range_a: assert property (
    xfer_valid |-> int'(xfer_chan) < NCH) else $error("bad channel");
  cover property ($rose(xfer_valid));
  cover property ($rose(irq));
  cover property (xfer_valid && xfer_word && xfer_chan == 2'd1);
endmodule

bind dstc_channel_ctrl dstc_channel_ctrl_chk #(.NCH(NCH)) i_chk (
  .clk(clk), .rst_n(rst_n), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .periph_evt(periph_evt), .xfer_valid(xfer_valid),
  .xfer_done(xfer_done), .xfer_src_addr(xfer_src_addr),
  .xfer_dst_addr(xfer_dst_addr), .xfer_word(xfer_word),
  .xfer_chan(xfer_chan), .irq(irq));

// File: sim/dstc_bus_model.sv
`timescale 1ns/1ps
// System bus model: finishes each request after a chosen wait.
module dstc_bus_model (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic xfer_valid, // Request from the engine.
  input wire logic [3:0] lat, // Wait cycles before finishing.
  output logic xfer_done // One-cycle completion pulse.
);
  logic [3:0] wait_q; // Cycles the request has waited.
  // Counts while a request stands, then pulses done once.
  always_ff @(posedge clk) begin
    if (!rst_n || !xfer_valid || xfer_done) begin
      wait_q <= 4'h0;
      xfer_done <= 1'b0;
    end else if (wait_q >= lat) begin
      xfer_done <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// File: sim/dstc_channel_ctrl_bench.sv
`timescale 1ns/1ps
// Register-level tests of the channel control block.
module dstc_channel_ctrl_bench;
  import dstc_pkg::*;
  logic clk = 1'b0; // System clock.
  logic rst_n = 1'b0; // Reset, active low.
  logic ce = 1'b1; // Clock enable, low only for the freeze test.
  logic [5:0] reg_addr = 6'h00; // Register address.
  logic [15:0] reg_wdata = 16'h0000; // Write data.
  logic reg_we = 1'b0; // Write strobe.
  logic reg_re = 1'b0; // Read strobe.
  logic [7:0] periph_evt = 8'h00; // Peripheral events.
  logic [3:0] lat = 4'h0; // Bus wait cycles.
  logic [15:0] reg_rdata; // Read data.
  logic xfer_valid, xfer_done, xfer_word, irq; // Transfer handshake.
  logic [23:0] xfer_src_addr, xfer_dst_addr; // Transfer addresses.
  logic [1:0] xfer_chan; // Owning channel.
  logic [3:0] codes [8] = '{SRC_ADC_END, SRC_SER0_TX, SRC_SER0_RX,
    SRC_SER1_TX, SRC_SER1_RX, SRC_TMR0_A, SRC_TMR1_A, SRC_TMR2_A};
  int errors = 0; // Mismatches.
  int num_checks = 0; // Comparisons.
  int b; // Event bit of a code, or -1.
  logic [15:0] m; // Memory pointer tracked for channel 3.
  always #2.5 clk = ~clk;
  dstc_channel_ctrl #(.NCH(4)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .periph_evt(periph_evt),
    .xfer_valid(xfer_valid), .xfer_done(xfer_done),
    .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
    .xfer_word(xfer_word), .xfer_chan(xfer_chan), .irq(irq));
  dstc_bus_model i_bus (.clk(clk), .rst_n(rst_n), .xfer_valid(xfer_valid),
    .lat(lat), .xfer_done(xfer_done));
  // Compares one value and counts the result.
  task automatic chk(input string n, input logic [23:0] s,
    input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // One write cycle.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // One read cycle; data is taken in the cycle after the strobe.
  task automatic rd(input string n, input logic [5:0] a,
    input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(n, {8'h00, reg_rdata}, {8'h00, e});
  endtask
  // Programs a whole channel, enable last.
  task automatic setup(input logic [2:0] c, input logic [7:0] ctl,
    input logic [15:0] mlo, input logic [15:0] io, input logic [15:0] cnt,
    input logic [1:0] en);
    wr({c, OFS_CTRL}, {8'h00, ctl});
    wr({c, OFS_MEM_LO}, mlo);
    wr({c, OFS_MEM_HI}, 16'h0000);
    wr({c, OFS_IO}, io);
    wr({c, OFS_CNT}, cnt);
    wr({c, OFS_EN}, {14'h0000, en});
  endtask
  // Pulses events, checks the granted transfer, waits for its end.
  task automatic xfer(input logic [7:0] ev, input logic [23:0] s,
    input logic [23:0] d, input logic w, input logic [1:0] ch);
    int n;
    n = 0;
    @(posedge clk);
    periph_evt <= ev;
    @(posedge clk);
    periph_evt <= 8'h00;
    do begin @(posedge clk); #1; n++; end
    while (xfer_valid !== 1'b1 && n < 20);
    chk("xfer_valid", xfer_valid, 24'h1);
    chk("xfer_src_addr", xfer_src_addr, s);
    chk("xfer_dst_addr", xfer_dst_addr, d);
    chk("xfer_word", xfer_word, w);
    chk("xfer_chan", xfer_chan, ch);
    do begin @(posedge clk); #1; n++; end
    while (xfer_valid !== 1'b0 && n < 40);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report;
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd("ctrl_reset", {c[2:0], OFS_CTRL}, 16'h0000);
      wr({c[2:0], OFS_CTRL}, 16'hAA50 | 16'(c));
    end
    for (int c = 0; c < 4; c++) begin
      rd("ctrl_rw", {c[2:0], OFS_CTRL}, 16'h0050 | 16'(c));
    end
    rd("unmapped", 6'h3F, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h000F);
    $display("test registers done");
    // Sequential bytes upward, memory to I/O, ending with an interrupt.
    setup(3'd0, {4'h0, SRC_ADC_END}, 16'h1234, 16'hABCD, 16'h0002, 2'b11);
    xfer(8'h01, 24'h001234, 24'hFFABCD, 1'b0, 2'd0);
    xfer(8'h01, 24'h001235, 24'hFFABCD, 1'b0, 2'd0);
    rd("enable_cleared", {3'd0, OFS_EN}, 16'h0002);
    chk("irq_set", irq, 24'h1);
    rd("status", ADDR_IRQ_STAT, 16'h0001);
    wr(ADDR_IRQ_STAT, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk("irq_clear", irq, 24'h0);
    $display("test sequential done");
    // Repeat mode, words downward, I/O to memory, slow bus.
    lat = 4'h3;
    setup(3'd1, {4'hF, SRC_TMR2_A}, 16'h0100, 16'h0040, 16'h0202, 2'b01);
    xfer(8'h80, 24'hFF0040, 24'h000100, 1'b1, 2'd1);
    xfer(8'h80, 24'hFF0040, 24'h0000FE, 1'b1, 2'd1);
    xfer(8'h80, 24'hFF0040, 24'h000100, 1'b1, 2'd1);
    rd("repeat_count", {3'd1, OFS_CNT}, 16'h0201);
    rd("repeat_enable", {3'd1, OFS_EN}, 16'h0001);
    rd("repeat_no_irq", ADDR_IRQ_STAT, 16'h0000);
    wr({3'd1, OFS_EN}, 16'h0000);
    $display("test repeat done");
    // Idle mode keeps the pointer although downward stepping is set.
    setup(3'd2, {4'h6, SRC_SER0_RX}, 16'h0200, 16'h0010, 16'h0002, 2'b11);
    xfer(8'h04, 24'h000200, 24'hFF0010, 1'b0, 2'd2);
    xfer(8'h04, 24'h000200, 24'hFF0010, 1'b0, 2'd2);
    rd("idle_status", ADDR_IRQ_STAT, 16'h0004);
    chk("irq_idle", irq, 24'h1);
    // Masking the only set status bit must drop the interrupt line.
    wr(ADDR_IRQ_MASK, 16'h000B);
    repeat (2) @(posedge clk);
    #1 chk("irq_masked", irq, 24'h0);
    wr(ADDR_IRQ_MASK, 16'h000F);
    wr(ADDR_IRQ_STAT, 16'h0004);
    $display("test idle done");
    // Every activation code on channel 3; unassigned codes stay silent.
    lat = 4'h0;
    m = 16'h0000;
    setup(3'd3, 8'h00, 16'h0000, 16'h0000, 16'h0000, 2'b01);
    for (int k = 0; k < 16; k++) begin
      wr({3'd3, OFS_CTRL}, 16'(k));
      b = -1;
      for (int j = 0; j < 8; j++) if (codes[j] == 4'(k)) b = j;
      if (b >= 0) begin
        xfer(8'h01 << b, {8'h00, m}, 24'hFF0000, 1'b0, 2'd3);
        m = m + 16'h0001;
      end else begin
        @(posedge clk);
        periph_evt <= 8'hFF;
        @(posedge clk);
        periph_evt <= 8'h00;
        repeat (4) begin
          @(posedge clk);
          #1 chk("no_grant", xfer_valid, 24'h0);
        end
      end
    end
    wr({3'd3, OFS_EN}, 16'h0000);
    // A write taken while the clock enable is low must not land.
    @(posedge clk);
    ce <= 1'b0;
    wr(ADDR_IRQ_MASK, 16'h0000);
    ce <= 1'b1;
    rd("ce_freeze", ADDR_IRQ_MASK, 16'h000F);
    $display("test sources done");
    // Two channels share timer 0; the lower channel goes first.
    lat = 4'h3;
    setup(3'd1, {4'h0, SRC_TMR0_A}, 16'h0300, 16'h0000, 16'h0000, 2'b01);
    setup(3'd0, {4'h0, SRC_TMR0_A}, 16'h0400, 16'h0000, 16'h0000, 2'b01);
    xfer(8'h20, 24'h000400, 24'hFF0000, 1'b0, 2'd0);
    xfer(8'h00, 24'h000300, 24'hFF0000, 1'b0, 2'd1);
    $display("test priority done");
    final_report;
  end
endmodule
